//--- logic/rtcra_defs.svh
/*
 * Constants of the RTC reset, alarm and interrupt-source slice: register
 * offsets, field positions, reset values and timing counts.
 * Assumes inclusion by bare name from logic/ sources and one 250 MHz clock.
 */
`ifndef RTCRA_DEFS_SVH
`define RTCRA_DEFS_SVH

// ============================================================
// Register byte offsets on the AXI4-Lite slave.
`define RTCRA_OFF_RESET 8'h00
`define RTCRA_OFF_PAGE 8'h04
`define RTCRA_OFF_MIN 8'h08
`define RTCRA_OFF_HOUR 8'h0C
`define RTCRA_OFF_DATE 8'h10
`define RTCRA_OFF_WDAY 8'h14
`define RTCRA_OFF_STAT 8'h18
`define RTCRA_OFF_CAL 8'h1C

// ============================================================
// Reset/source-select register fields.
`define RTCRA_B_ONEHZ_OFF 7
`define RTCRA_B_SIXTEENHZ_OFF 6
`define RTCRA_B_SECRST 5
`define RTCRA_B_ALMRST 4
`define RTCRA_RESET_RV 8'hC7
`define RTCRA_RESET_ONES 8'h07

// Page control register fields.
`define RTCRA_B_INTEN 7
`define RTCRA_B_RUN 3
`define RTCRA_B_ALMEN 2
`define RTCRA_B_PAGE 0
`define RTCRA_PAGE_MASK 8'h8D

// Alarm field reset values: minute 00, hour 00, day 01, Sunday (0).
`define RTCRA_ALM_MIN_RV 8'h00
`define RTCRA_ALM_HOUR_RV 8'h00
`define RTCRA_ALM_DATE_RV 8'h01
`define RTCRA_ALM_WDAY_RV 8'h00

// ============================================================
// Timing: 250 MHz clock, 32.768 kHz slow clock.
`define RTCRA_CLK_HZ 250000000
`define RTCRA_SLOW_HZ 32768
`define RTCRA_SLOW_DIV (`RTCRA_CLK_HZ / `RTCRA_SLOW_HZ)
`define RTCRA_SEC_TICKS 32768
`define RTCRA_SIXTEEN_TICKS 2048

`endif

//--- logic/rtcra_match.sv
/*
 * Alarm comparator: registered equality of time and alarm fields.
 * Assumes fields held stable by the parent between slow ticks.
 */
`timescale 1ns/100ps
`default_nettype none
module rtcra_match
   import rtcra_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [31:0] now_fields,
   input wire logic [31:0] alm_fields,
   output logic equal
);
   typedef struct packed {
      logic eq;
   } rtcra_cmp_t;
   rtcra_cmp_t c_q, c_d;

   // ============================================================
   // Compare minute, hour, date and weekday in one step.
   always_comb begin
      c_d = c_q;
      c_d.eq = (now_fields == alm_fields);
   end

   // State register.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         c_q <= '0;
      end else begin
         c_q <= c_d;
      end
   end

   assign equal = c_q.eq;
endmodule
`default_nettype wire

//--- logic/rtcra_pkg.sv
/*
 * Types of the RTC reset, alarm and interrupt-source slice.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rtcra_pkg;
   // ============================================================
   // Interrupt source chosen from the disable and enable bits.
   typedef enum logic [1:0] {RTCRA_SRC_NONE, RTCRA_SRC_ALARM,
                             RTCRA_SRC_1HZ, RTCRA_SRC_16HZ} rtcra_src_t;

   // Bus slave phases.
   typedef enum logic [1:0] {RTCRA_W_IDLE, RTCRA_W_RESP} rtcra_wst_t;
endpackage

//--- logic/rtcra_slow_tick.sv
/*
 * Slow clock generator: a one-cycle enable at 32.768 kHz and a divide
 * counter from the 250 MHz clock.
 * Assumes the parent uses the pulse as the only slow-rate step.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rtcra_defs.svh"
module rtcra_slow_tick
   import rtcra_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   output logic slow_tick
);
   typedef struct packed {
      logic [12:0] cnt;
      logic tick;
   } rtcra_div_t;
   rtcra_div_t s_q, s_d;

   // ============================================================
   // Divider; fractional rate error is accepted to keep it small.
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == 13'(`RTCRA_SLOW_DIV - 1)) begin
         s_d.cnt = 13'h0000;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 13'h0001;
      end
   end

   // State register.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign slow_tick = s_q.tick;
endmodule
`default_nettype wire

//--- logic/rtcra_top.sv
/*
 * RTC reset, alarm and interrupt-source slice with an AXI4-Lite slave.
 * Assumes a single AXI4-Lite master with one read and one write in flight.
 */
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "rtcra_defs.svh"
module rtcra_top
   import rtcra_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic alarm_n,
   output logic rtc_interrupt,
   output logic sec_tick
);
   typedef struct packed {
      logic [7:0] awaddr;
      logic aw_have;
      logic [7:0] wdata;
      logic w_have;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic one_hz_disable;
      logic sixteen_hz_disable;
      logic sec_rst_pend;
      logic alm_rst_pend;
      logic interrupt_output_enable;
      logic clock_run_enable;
      logic alarm_enable;
      logic alarm_page;
      logic [14:0] sec_cnt;
      logic [31:0] now;
      logic [31:0] alm;
      logic match_prev;
      logic alarm_n;
      logic irq;
      logic sec_tick;
      logic pend_1hz;
      logic aw_rdy;
      logic w_rdy;
      logic ar_rdy;
   } rtcra_state_t;
   rtcra_state_t s_q, s_d;

   logic slow_tick;
   logic equal;

   // ============================================================
   // Slow-rate step and alarm comparator.
   rtcra_slow_tick u_tick (
      .clk(clk),
      .sys_rst(sys_rst),
      .slow_tick(slow_tick)
   );

   rtcra_match u_match (
      .clk(clk),
      .sys_rst(sys_rst),
      .now_fields(s_q.now),
      .alm_fields(s_q.alm),
      .equal(equal)
   );

   // Source decode from the two disable bits and the alarm enable.
   function automatic rtcra_src_t src_of(input logic d1, input logic d16,
                                         input logic ae);
      case ({d1, d16, ae})
         3'b111: src_of = RTCRA_SRC_ALARM;
         3'b010: src_of = RTCRA_SRC_1HZ;
         3'b100: src_of = RTCRA_SRC_16HZ;
         default: src_of = RTCRA_SRC_NONE;
      endcase
   endfunction

   // Word view of a register for readback.
   function automatic logic [31:0] rd_word(input rtcra_state_t s,
                                           input logic [7:0] a);
      rd_word = 32'h0000_0000;
      case (a)
         `RTCRA_OFF_RESET: begin
            rd_word[`RTCRA_B_ONEHZ_OFF] = s.one_hz_disable;
            rd_word[`RTCRA_B_SIXTEENHZ_OFF] = s.sixteen_hz_disable;
            rd_word[`RTCRA_B_SECRST] = s.sec_rst_pend;
            rd_word[`RTCRA_B_ALMRST] = s.alm_rst_pend;
            rd_word[7:0] = rd_word[7:0] | `RTCRA_RESET_ONES;
         end
         `RTCRA_OFF_PAGE: begin
            rd_word[`RTCRA_B_INTEN] = s.interrupt_output_enable;
            rd_word[`RTCRA_B_RUN] = s.clock_run_enable;
            rd_word[`RTCRA_B_ALMEN] = s.alarm_enable;
            rd_word[`RTCRA_B_PAGE] = s.alarm_page;
         end
         `RTCRA_OFF_MIN: rd_word[7:0] = s.alarm_page ? s.alm[31:24] :
                                         s.now[31:24];
         `RTCRA_OFF_HOUR: rd_word[7:0] = s.alarm_page ? s.alm[23:16] :
                                          s.now[23:16];
         `RTCRA_OFF_DATE: rd_word[7:0] = s.alarm_page ? s.alm[15:8] :
                                          s.now[15:8];
         `RTCRA_OFF_WDAY: rd_word[7:0] = s.alarm_page ? s.alm[7:0] :
                                          s.now[7:0];
         `RTCRA_OFF_STAT: rd_word[14:0] = s.sec_cnt;
         default: rd_word = 32'h0000_0000;
      endcase
   endfunction

   // Address is mapped when it hits one of the registers.
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `RTCRA_OFF_RESET) || (a == `RTCRA_OFF_PAGE) ||
               (a == `RTCRA_OFF_MIN) || (a == `RTCRA_OFF_HOUR) ||
               (a == `RTCRA_OFF_DATE) || (a == `RTCRA_OFF_WDAY) ||
               (a == `RTCRA_OFF_STAT) || (a == `RTCRA_OFF_CAL);
   endfunction

   // ============================================================
   // Next state: bus slave, register writes and slow-clock logic.
   always_comb begin
      logic wr_go;
      logic [7:0] wv;
      logic sec_wrap;
      logic sixteen;
      logic match_edge;
      logic event_now;
      rtcra_src_t src;
      logic sec_set;
      logic alm_set;
      wr_go = 1'b0;
      sec_set = 1'b0;
      alm_set = 1'b0;
      wv = 8'h00;
      sec_wrap = 1'b0;
      sixteen = 1'b0;
      match_edge = 1'b0;
      event_now = 1'b0;
      src = RTCRA_SRC_NONE;
      s_d = s_q;

      // Write channels are taken in either order and held until both.
      if (s_axi_awvalid && !s_q.aw_have && !s_q.bvalid) begin
         s_d.awaddr = s_axi_awaddr;
         s_d.aw_have = 1'b1;
      end
      if (s_axi_wvalid && !s_q.w_have && !s_q.bvalid) begin
         s_d.wdata = s_axi_wdata[7:0];
         s_d.w_lane0 = s_axi_wstrb[0];
         s_d.w_have = 1'b1;
      end
      if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
         wr_go = s_q.w_lane0 && mapped(s_q.awaddr);
         wv = s_q.wdata;
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = mapped(s_q.awaddr) ? 2'b00 : 2'b10;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end

      // Reads answer one cycle after address acceptance.
      if (s_axi_arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = rd_word(s_q, s_axi_araddr);
         s_d.rresp = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end

      // Register writes; byte lane 0 only, and each register stores only its own fields.
      if (wr_go) begin
         case (s_q.awaddr)
            `RTCRA_OFF_RESET: begin
               // Bits 3 to 0 are not stored; their read values are fixed.
               s_d.one_hz_disable = wv[`RTCRA_B_ONEHZ_OFF];
               s_d.sixteen_hz_disable = wv[`RTCRA_B_SIXTEENHZ_OFF];
               if (wv[`RTCRA_B_SECRST]) begin
                  s_d.sec_rst_pend = 1'b1;
                  sec_set = 1'b1;
               end
               if (wv[`RTCRA_B_ALMRST]) begin
                  s_d.alm_rst_pend = 1'b1;
                  alm_set = 1'b1;
               end
            end
            `RTCRA_OFF_PAGE: begin
               s_d.interrupt_output_enable = wv[`RTCRA_B_INTEN];
               s_d.clock_run_enable = wv[`RTCRA_B_RUN];
               s_d.alarm_enable = wv[`RTCRA_B_ALMEN];
               s_d.alarm_page = wv[`RTCRA_B_PAGE];
               if (wv[`RTCRA_B_INTEN] && !s_q.interrupt_output_enable) begin
                  // Clears pend_1hz only; sec_cnt is not restarted, so the 1 Hz timing is unchanged.
                  s_d.pend_1hz = 1'b0;
               end
            end
            `RTCRA_OFF_MIN: begin
               if (s_q.alarm_page) s_d.alm[31:24] = wv;
               else s_d.now[31:24] = wv;
            end
            `RTCRA_OFF_HOUR: begin
               if (s_q.alarm_page) s_d.alm[23:16] = wv;
               else s_d.now[23:16] = wv;
            end
            `RTCRA_OFF_DATE: begin
               if (s_q.alarm_page) s_d.alm[15:8] = wv;
               else s_d.now[15:8] = wv;
            end
            `RTCRA_OFF_WDAY: begin
               if (s_q.alarm_page) s_d.alm[7:0] = wv;
               else s_d.now[7:0] = wv;
            end
            default: s_d.alm_rst_pend = s_d.alm_rst_pend;
         endcase
      end

      // Readies come from the next state so each bus output leaves a
      // flip-flop while still matching the hold flags cycle for cycle.
      s_d.aw_rdy = !s_d.aw_have && !s_d.bvalid;
      s_d.w_rdy = !s_d.w_have && !s_d.bvalid;
      s_d.ar_rdy = !s_d.rvalid;

      // sec_tick falls back every clock; irq and alarm_n fall back at each slow step.
      s_d.sec_tick = 1'b0;
      s_d.irq = 1'b0;
      s_d.alarm_n = 1'b1;

      // Slow-clock step: requests and the seconds chain act only here.
      if (slow_tick) begin
         if (s_q.sec_rst_pend) begin
            s_d.sec_cnt = 15'h0000;
            // A request written in this very cycle wins over completion,
            // so a repeated request is never lost.
            s_d.sec_rst_pend = sec_set;
         end else begin
            s_d.sec_cnt = s_q.sec_cnt + 15'h0001;
            sec_wrap = (s_q.sec_cnt == 15'(`RTCRA_SEC_TICKS - 1));
         end
         if (s_q.alm_rst_pend) begin
            s_d.alm = {`RTCRA_ALM_MIN_RV, `RTCRA_ALM_HOUR_RV,
                       `RTCRA_ALM_DATE_RV, `RTCRA_ALM_WDAY_RV};
            s_d.alm_rst_pend = alm_set;
         end
         sixteen = (s_q.sec_cnt[10:0] ==
                    11'(`RTCRA_SIXTEEN_TICKS - 1));
         s_d.sec_tick = sec_wrap;
         // The pend_1hz toggle on a second wrap stops with run cleared.
         if (sec_wrap && s_q.clock_run_enable) begin
            s_d.pend_1hz = ~s_q.pend_1hz;
         end
         match_edge = equal && !s_q.match_prev;
         s_d.match_prev = equal;
         src = src_of(s_q.one_hz_disable, s_q.sixteen_hz_disable,
                      s_q.alarm_enable);
         case (src)
            RTCRA_SRC_ALARM: event_now = match_edge && s_q.alarm_page;
            RTCRA_SRC_1HZ: event_now = sec_wrap;
            RTCRA_SRC_16HZ: event_now = sixteen;
            default: event_now = 1'b0;
         endcase
         if (event_now && s_q.interrupt_output_enable) begin
            s_d.alarm_n = 1'b0;
            s_d.irq = 1'b1;
         end
      end else begin
         // Hold the pin pulse for the whole slow cycle.
         s_d.alarm_n = s_q.alarm_n;
         s_d.irq = s_q.irq;
      end
   end

   // ============================================================
   // State register with documented reset values.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.one_hz_disable <= 1'b1;
         s_q.sixteen_hz_disable <= 1'b1;
         s_q.alarm_n <= 1'b1;
         s_q.aw_rdy <= 1'b1;
         s_q.w_rdy <= 1'b1;
         s_q.ar_rdy <= 1'b1;
         s_q.alm <= {`RTCRA_ALM_MIN_RV, `RTCRA_ALM_HOUR_RV,
                     `RTCRA_ALM_DATE_RV, `RTCRA_ALM_WDAY_RV};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register.
   assign s_axi_awready = s_q.aw_rdy;
   assign s_axi_wready = s_q.w_rdy;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = s_q.ar_rdy;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign alarm_n = s_q.alarm_n;
   assign rtc_interrupt = s_q.irq;
   assign sec_tick = s_q.sec_tick;
endmodule
`default_nettype wire

//--- test/rtcra_chk.sv
/*
 * Port checker for the RTC slice: bus answer timing and the alarm event.
 * Assumes it is bound to rtcra_top and that the defs header is on the path.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rtcra_defs.svh"
module rtcra_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic alarm_n,
   input wire logic rtc_interrupt,
   input wire logic sec_tick
);
   localparam int DIV = `RTCRA_SLOW_DIV;
   logic [15:0] hi_q;
   logic [15:0] hi_d;

   // ============================================================
   // Pulse length counter; cleared while the interrupt is low.
   always_comb begin
      hi_d = rtc_interrupt ? hi_q + 16'h0001 : 16'h0000;
   end

   // Reset clears the count so a pulse cut by reset is not measured.
   always_ff @(posedge clk) begin
      hi_q <= sys_rst ? 16'h0000 : hi_d;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // ============================================================
   // Assertions.
   chk_pin_irq_pair: assert property (rtc_interrupt == !alarm_n)
      else $error("alarm pin and interrupt disagree");
   chk_irq_width: assert property (
      $fell(rtc_interrupt) |-> hi_q == DIV)
      else $error("interrupt pulse not one slow cycle");
   chk_irq_bound: assert property (rtc_interrupt |-> hi_q < DIV)
      else $error("interrupt pulse too long");
   chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read response late");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_busy_refuse: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while answering");
   chk_ar_free: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("read address ready wrong");

   // Main scenarios reached.
   cover property ($rose(rtc_interrupt));
   cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
   cover property (s_axi_rvalid && s_axi_rdata[5]);
endmodule

bind rtcra_top rtcra_chk u_chk (.clk(clk), .sys_rst(sys_rst),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .alarm_n(alarm_n),
   .rtc_interrupt(rtc_interrupt), .sec_tick(sec_tick));
`default_nettype wire

//--- test/tb_rtcra_top.sv
/*
 * Self-checking bench for the RTC slice: registers, request bits and the
 * alarm event. Assumes the defs header on the include path, 250 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rtcra_defs.svh"
module tb_rtcra_top;
   localparam int DIV = `RTCRA_SLOW_DIV;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic lazy = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, alarm_n, irq, sec_tick;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd;
   logic [7:0] t [4];
   logic [7:0] rs [3] = '{8'h47, 8'hC7, 8'hC7};
   logic [7:0] pg [3] = '{8'h85, 8'h05, 8'h85};
   int errors = 0;
   int num_checks = 0;
   int i, k, n;

   // ============================================================
   // Clock and design.
   always #2 clk = ~clk;

   rtcra_top DUT (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .alarm_n(alarm_n), .rtc_interrupt(irq),
      .sec_tick(sec_tick));

   // ============================================================
   // Comparison, bus tasks and expectations.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Address and data go out together; each drops once taken.
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s = 4'h1);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= !lazy;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid && bready));
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd8(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= !lazy;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready));
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      rd8(a);
      check(rd, e);
   endtask

   function automatic logic [7:0] fa(input int f);
      return 8'(8 + 4 * f);
   endfunction

   function automatic logic [7:0] alm_rv(input int f);
      return (f == 2) ? `RTCRA_ALM_DATE_RV : `RTCRA_ALM_MIN_RV;
   endfunction

   // Only the all-ones source setting with interrupt enabled may fire.
   function automatic logic fires(input logic [7:0] r, input logic [7:0] p);
      return r[7] & r[6] & p[7] & p[2] & p[0];
   endfunction

   task test_done;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // A hang is cut short well past the expected run length.
   initial begin
      repeat (90000) @(posedge clk);
      errors++;
      test_done;
   end

   // ============================================================
   // Main sequence.
   initial begin
      void'($urandom(84));
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      rdchk(8'h00, 32'h0000_00C7);
      rdchk(8'h04, 32'h0000_0000);
      wr(8'h04, 8'h01);
      for (i = 0; i < 4; i++) rdchk(fa(i), alm_rv(i));
      // Unmapped place and a write with its byte lane off.
      wr(8'h20, 8'h55);
      check(resp, 2'b10);
      rd8(8'h20);
      check(resp, 2'b10);
      wr(8'h00, 8'h07, 4'h0);
      rdchk(8'h00, 32'h0000_00C7);
      // Random traffic; bit 3 is written at random and must read zero.
      for (i = 0; i < 8; i++) begin
         n = $urandom;
         lazy = n[3];
         wr(8'h00, {n[1:0], 2'b00, n[2], 3'b111});
         rdchk(8'h00, {24'h00_0000, n[1:0], 6'b00_0111});
         wr(8'h04, n[15:8]);
         rdchk(8'h04, {24'h00_0000, n[15:8] & `RTCRA_PAGE_MASK});
         wr(fa(n[17:16]), n[31:24]);
         rdchk(fa(n[17:16]), {24'h00_0000, n[31:24]});
      end
      wr(8'h04, 8'h00);
      // Seconds reset reads pending, then clears within a slow cycle.
      wr(8'h00, 8'hE7);
      rd8(8'h00);
      check(rd[5], 1'b1);
      n = 0;
      do begin
         rd8(8'h00);
         n++;
      end while (rd[5] === 1'b1 && n < 2600);
      check(rd, 32'h0000_00C7);
      rd8(8'h18);
      check(rd[31:1], 31'h0000_0000);
      // Alarm field reset over random contents.
      wr(8'h04, 8'h01);
      for (i = 0; i < 4; i++) wr(fa(i), 8'($urandom));
      wr(8'h00, 8'hD7);
      repeat (DIV + 10) @(posedge clk);
      for (i = 0; i < 4; i++) rdchk(fa(i), alm_rv(i));
      // Time fields, then alarm fields with the minute inverted.
      wr(8'h04, 8'h00);
      for (i = 0; i < 4; i++) begin
         t[i] = 8'($urandom);
         wr(fa(i), t[i]);
      end
      for (i = 0; i < 4; i++) repeat (2) rdchk(fa(i), t[i]);
      wr(8'h04, 8'h01);
      for (i = 0; i < 4; i++) wr(fa(i), (i == 0) ? ~t[0] : t[i]);
      // Each setting gets a fresh match edge; only the last may fire.
      for (k = 0; k < 3; k++) begin
         wr(8'h00, rs[k]);
         wr(8'h04, 8'h05);
         wr(8'h04, pg[k]);
         repeat (DIV + 10) @(posedge clk);
         wr(8'h08, t[0]);
         n = 0;
         // The event falls on the first slow step after the match.
         while (!irq && n < DIV + 16) begin
            @(posedge clk);
            n++;
         end
         check(irq, fires(rs[k], pg[k]));
         check(alarm_n, !fires(rs[k], pg[k]));
         if (irq) begin
            n = 0;
            while (irq && n < 2 * DIV) begin
               @(posedge clk);
               n++;
            end
            check(n, DIV);
         end
         wr(8'h04, 8'h01);
         wr(8'h08, ~t[0]);
      end
      test_done;
   end
endmodule
`default_nettype wire
